/* File: sbc_mode_pkg.sv */
// constants for the mode control register of the system basis chip
// shared by the register block and its verification; no logic here
package sbc_mode_pkg;
	// frame layout of the 16-bit serial word
	localparam int FRAME_BITS = 16;
	localparam logic [2:0] REG_ADDR = 3'h1;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 13;
	localparam int LOCK_POS = 12;
	localparam int MODE_MSB = 11;
	localparam int MODE_LSB = 10;
	localparam int WARN_POS = 9;
	localparam int FALLBACK_POS = 8;
	localparam int ENABLE_POS = 7;
	localparam int BIAS_POS = 5;
	localparam int SHARE_POS = 4;
	// power-on values
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic WARN_RESET = 1'h1;
	localparam logic FALLBACK_RESET = 1'h0;
	localparam logic ENABLE_RESET = 1'h0;
	localparam logic BIAS_RESET = 1'h0;
	localparam logic SHARE_RESET = 1'h0;
	// operating mode encodings
	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_SLEEP = 2'h1;
	localparam logic [1:0] MODE_NORMAL_SUPPLY_OFF = 2'h2;
	localparam logic [1:0] MODE_NORMAL_SUPPLY_ON = 2'h3;
	// external transistor thresholds in mA, per share select value
	localparam int SHARE0_ON_MA = 85;
	localparam int SHARE0_OFF_MA = 50;
	localparam int SHARE1_ON_MA = 50;
	localparam int SHARE1_OFF_MA = 15;
	// wake sampling timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SAMPLE_SHORT_MS = 16;
	localparam int SAMPLE_LONG_MS = 64;
	localparam int CYCLES_PER_MS = 1000000 / CLK_PERIOD_NS;
endpackage

/* File: mode_control_reg.sv */
// mode control register reached over a 16-bit serial frame, with pin drivers
// assumes the serial pins are asynchronous and that system_reset_in comes from core_clk_in logic
//
// Functional notes
// - frame lock bit set means read only; writes to control fields are dropped.
// - mode field 00 standby, 01 sleep, 10 normal supply off, 11 normal on.
// - armed fallback warning makes the next system reset activate the fallback output.
// - every reset forces the fallback warning bit to one.
// - fallback drive bit zero floats the fallback pin, one drives it low.
// - reset sets fallback drive only if the warning bit was one before.
// - enable pin low when control is zero; high only in normal mode otherwise.
// - bias bit floats or lows the bias pin, or picks 16/64 ms sampling.
// - share bit picks transistor thresholds 85/50 mA or 50/15 mA.
// - per-input sample select syncs that wake input to bias rate, else continuous.
`timescale 1ns/1ns
module mode_control_reg #(
	parameter int CYCLES_PER_MS = sbc_mode_pkg::CYCLES_PER_MS
) (
	input  wire logic       core_clk_in,
	input  wire logic       reset_in,
	input  wire logic       system_reset_in,
	input  wire logic       spi_sck_in,
	input  wire logic       spi_sdi_in,
	input  wire logic       spi_cs_n_in,
	input  wire logic [1:0] wake_sample_select_in,
	output logic            spi_sdo_out,
	output logic            spi_sdo_oe_out,
	output logic [1:0]      operating_mode_select_out,
	output logic            normal_mode_out,
	output logic            transceiver_supply_on_out,
	output logic            fallback_out,
	output logic            fallback_oe_out,
	output logic            enable_pin_out,
	output logic            wake_bias_pin_out,
	output logic            wake_bias_pin_oe_out,
	output logic [1:0]      wake_sample_strobe_out,
	output logic            power_share_select_out,
	output logic [7:0]      share_on_ma_out,
	output logic [7:0]      share_off_ma_out
);
	localparam int MS_W = $clog2(CYCLES_PER_MS + 1);
	localparam logic [MS_W-1:0] MS_LAST = MS_W'(CYCLES_PER_MS - 1);
	localparam logic [6:0] SHORT_LAST = 7'(sbc_mode_pkg::SAMPLE_SHORT_MS - 1);
	localparam logic [6:0] LONG_LAST = 7'(sbc_mode_pkg::SAMPLE_LONG_MS - 1);

	// register fields
	logic [1:0] operating_mode_select;
	logic       fallback_warning_arm;
	logic       fallback_output_drive;
	logic       enable_pin_control;
	logic       wake_bias_rate_select;
	logic       power_share_select;

	// serial front end
	logic [2:0]  sck_sync;
	logic [1:0]  sdi_sync;
	logic [2:0]  cs_sync;
	logic [15:0] shift_in;
	logic [15:0] shift_out;
	logic [4:0]  bit_count;
	logic        sdo;

	// wake sampling timebase
	logic [MS_W-1:0] ms_count;
	logic [6:0]      period_count;
	logic            period_tick;

	wire        sck_rise = sck_sync[1] & ~sck_sync[2];
	wire        sck_fall = ~sck_sync[1] & sck_sync[2];
	wire        selected = ~cs_sync[1];
	wire        cs_fall = ~cs_sync[1] & cs_sync[2];
	wire        cs_rise = cs_sync[1] & ~cs_sync[2];
	wire        frame_full = bit_count == 5'(sbc_mode_pkg::FRAME_BITS);
	wire        addr_hit = shift_in[sbc_mode_pkg::ADDR_MSB:sbc_mode_pkg::ADDR_LSB] == sbc_mode_pkg::REG_ADDR;
	wire        write_ok = cs_rise & frame_full & addr_hit & ~shift_in[sbc_mode_pkg::LOCK_POS];
	wire        ms_tick = ms_count == MS_LAST;
	wire [6:0]  period_last = wake_bias_rate_select ? LONG_LAST : SHORT_LAST;
	wire        sampling_on = |wake_sample_select_in;

	// readback word: address constant, lock and reserved bits zero
	wire [15:0] read_word = {sbc_mode_pkg::REG_ADDR, 1'b0, operating_mode_select, fallback_warning_arm,
		fallback_output_drive, enable_pin_control, 1'b0, wake_bias_rate_select, power_share_select,
		4'h0};

	// two flops on sdi, three on sck and cs; only the second and later stages are read
	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			sck_sync <= 3'h0;
			sdi_sync <= 2'h0;
			cs_sync <= 3'h7;
		end
		else
		begin
			sck_sync <= {sck_sync[1:0], spi_sck_in};
			sdi_sync <= {sdi_sync[0], spi_sdi_in};
			cs_sync <= {cs_sync[1:0], spi_cs_n_in};
		end
	end

	// shift in on rising clock, shift out on falling clock, msb first
	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			shift_in <= 16'h0;
			shift_out <= 16'h0;
			bit_count <= 5'h0;
			sdo <= 1'b0;
		end
		else if (cs_fall)
		begin
			bit_count <= 5'h0;
			shift_out <= {read_word[14:0], 1'b0};
			sdo <= read_word[15];
		end
		else if (selected)
		begin
			if (sck_rise)
			begin
				shift_in <= {shift_in[14:0], sdi_sync[1]};
				// saturate at 31 so an over-long frame never looks complete
				bit_count <= (&bit_count) ? bit_count : bit_count + 5'h1;
			end
			if (sck_fall)
			begin
				sdo <= shift_out[15];
				shift_out <= {shift_out[14:0], 1'b0};
			end
		end
	end

	// field storage; a system reset beats a write landing in the same cycle
	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			operating_mode_select <= sbc_mode_pkg::MODE_RESET;
			fallback_warning_arm <= sbc_mode_pkg::WARN_RESET;
			fallback_output_drive <= sbc_mode_pkg::FALLBACK_RESET;
			enable_pin_control <= sbc_mode_pkg::ENABLE_RESET;
			wake_bias_rate_select <= sbc_mode_pkg::BIAS_RESET;
			power_share_select <= sbc_mode_pkg::SHARE_RESET;
		end
		else if (system_reset_in)
		begin
			fallback_warning_arm <= 1'b1;
			if (fallback_warning_arm)
				fallback_output_drive <= 1'b1;
		end
		else if (write_ok)
		begin
			operating_mode_select <= shift_in[sbc_mode_pkg::MODE_MSB:sbc_mode_pkg::MODE_LSB];
			fallback_warning_arm <= shift_in[sbc_mode_pkg::WARN_POS];
			fallback_output_drive <= shift_in[sbc_mode_pkg::FALLBACK_POS];
			enable_pin_control <= shift_in[sbc_mode_pkg::ENABLE_POS];
			wake_bias_rate_select <= shift_in[sbc_mode_pkg::BIAS_POS];
			power_share_select <= shift_in[sbc_mode_pkg::SHARE_POS];
		end
	end

	// ms divider then period counter; a rate change does not restart the count
	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			ms_count <= '0;
			period_count <= 7'h0;
			period_tick <= 1'b0;
		end
		else
		begin
			ms_count <= ms_tick ? '0 : ms_count + MS_W'(1);
			period_tick <= ms_tick & (period_count >= period_last);
			if (ms_tick)
				period_count <= (period_count >= period_last) ? 7'h0 : period_count + 7'h1;
		end
	end

	// pin and decode outputs
	assign spi_sdo_out = sdo;
	assign spi_sdo_oe_out = selected;
	assign operating_mode_select_out = operating_mode_select;
	assign normal_mode_out = operating_mode_select[1];
	assign transceiver_supply_on_out = operating_mode_select == sbc_mode_pkg::MODE_NORMAL_SUPPLY_ON;
	assign fallback_out = 1'b0;
	assign fallback_oe_out = fallback_output_drive;
	assign enable_pin_out = enable_pin_control & operating_mode_select[1];
	assign wake_bias_pin_out = 1'b0;
	// while sampling the pin is held low; bias pulse shaping is left to the analogue side
	assign wake_bias_pin_oe_out = sampling_on | wake_bias_rate_select;
	assign power_share_select_out = power_share_select;
	assign share_on_ma_out = power_share_select ? 8'(sbc_mode_pkg::SHARE1_ON_MA)
		: 8'(sbc_mode_pkg::SHARE0_ON_MA);
	assign share_off_ma_out = power_share_select ? 8'(sbc_mode_pkg::SHARE1_OFF_MA)
		: 8'(sbc_mode_pkg::SHARE0_OFF_MA);

	// per-input strobe: gated by period tick or always on
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_wake
			assign wake_sample_strobe_out[gi] = wake_sample_select_in[gi] ? period_tick : 1'b1;
		end
	endgenerate

	// assertions
	lock_drops_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		cs_rise & frame_full & addr_hit & shift_in[sbc_mode_pkg::LOCK_POS] & ~system_reset_in
		|=> $stable(read_word)) else $error("locked frame changed register");
	mode_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		write_ok & ~system_reset_in |=>
		operating_mode_select == $past(shift_in[sbc_mode_pkg::MODE_MSB:sbc_mode_pkg::MODE_LSB])) else
		$error("mode field not written");
	supply_decode_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		transceiver_supply_on_out |-> normal_mode_out && operating_mode_select[0]) else
		$error("supply on outside normal mode");
	warn_forced_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		system_reset_in |=> fallback_warning_arm) else $error("warning not forced on reset");
	fallback_arm_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		system_reset_in && fallback_warning_arm |=> fallback_oe_out) else
		$error("armed reset did not drive fallback");
	fallback_keep_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		system_reset_in && !fallback_warning_arm |=> fallback_oe_out == $past(fallback_oe_out)) else
		$error("unarmed reset changed fallback");
	enable_pin_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		enable_pin_out |-> enable_pin_control && operating_mode_select[1]) else
		$error("enable pin high without cause");
	bias_float_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!sampling_on && !wake_bias_rate_select |-> !wake_bias_pin_oe_out) else
		$error("bias pin driven while floating");
	share_sel_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		share_on_ma_out == (power_share_select ? 8'h32 : 8'h55) &&
		share_off_ma_out == (power_share_select ? 8'h0f : 8'h32)) else
		$error("share thresholds wrong");
	strobe_cont_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!wake_sample_select_in[0] |-> wake_sample_strobe_out[0]) else
		$error("continuous sampling strobe low");
	addr_field_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		read_word[15:12] == 4'h2 && read_word[6] == 1'b0 && read_word[3:0] == 4'h0) else
		$error("fixed readback bits wrong");
endmodule

/* File: spi_host_model.sv */
// host side serial master model driving the mode control register frames
// assumes core_clk_in is the device clock; each sck phase lasts 5 clocks
`timescale 1ns/1ns
module spi_host_model (
	input  wire logic core_clk_in,
	input  wire logic spi_sdo_in,
	output logic      spi_sck_out,
	output logic      spi_sdi_out,
	output logic      spi_cs_n_out
);
	// idle: chip deselected, clock parked low
	initial
	begin
		spi_sck_out = 1'b0;
		spi_sdi_out = 1'b0;
		spi_cs_n_out = 1'b1;
	end
	// one frame msb first; nbits other than 16 makes a bad frame
	task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge core_clk_in) spi_cs_n_out = 1'b0;
		for (int i = 0; i < nbits; i++)
		begin
			spi_sdi_out = tx[15 - (i % 16)];
			repeat (5) @(negedge core_clk_in);
			rx = {rx[14:0], spi_sdo_in};
			spi_sck_out = 1'b1;
			repeat (5) @(negedge core_clk_in);
			spi_sck_out = 1'b0;
		end
		repeat (5) @(negedge core_clk_in);
		spi_cs_n_out = 1'b1;
		spi_sdi_out = ~spi_sdi_out; // released line shows no stale bit
		repeat (8) @(negedge core_clk_in);
	endtask
endmodule

/* File: mode_control_reg_test.sv */
// self-checking bench for the mode control register and its pin drivers
// assumes the serial host model file is compiled first
`timescale 1ns/1ns
module mode_control_reg_test;
	localparam int MS = 10; // short ms tick keeps wake periods brief
	logic        core_clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        system_reset_in = 1'b0;
	logic [1:0]  sel = 2'h0;
	wire logic   sck, sdi, cs_n, sdo, sdo_oe, normal, supply, fb, fb_oe, en, wb, wb_oe, share;
	wire logic [1:0] mode, strobe;
	wire logic [7:0] on_ma, off_ma;
	int          failures = 0;
	int          cmp_count = 0;
	logic [15:0] r, rx, w, cnt;
	spi_host_model host (.core_clk_in(core_clk_in), .spi_sdo_in(sdo), .spi_sck_out(sck), .spi_sdi_out(sdi),
		.spi_cs_n_out(cs_n));
	mode_control_reg #(.CYCLES_PER_MS(MS)) dut (.core_clk_in(core_clk_in), .reset_in(reset_in),
		.system_reset_in(system_reset_in), .spi_sck_in(sck), .spi_sdi_in(sdi), .spi_cs_n_in(cs_n),
		.wake_sample_select_in(sel), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe), .operating_mode_select_out(mode),
		.normal_mode_out(normal), .transceiver_supply_on_out(supply), .fallback_out(fb), .fallback_oe_out(fb_oe),
		.enable_pin_out(en), .wake_bias_pin_out(wb), .wake_bias_pin_oe_out(wb_oe), .wake_sample_strobe_out(strobe),
		.power_share_select_out(share), .share_on_ma_out(on_ma), .share_off_ma_out(off_ma));
	initial
	begin
		forever #5 core_clk_in = ~core_clk_in;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL %0t %s got %h want %h", $time, msg, got, exp);
		end
	endtask
	// stored view of a written word: address fixed, lock and reserved read zero
	function automatic logic [15:0] exp_word(input logic [15:0] d);
		return {3'h1, 1'b0, d[11:7], 1'b0, d[5:4], 4'h0};
	endfunction
	// locked read leaves the register alone, then pins follow the model
	task automatic rd_check();
		host.frame(16'h3000, 16, rx);
		check(rx, r, "readback");
		// data out released once the frame is over
		check({5'h0, sdo_oe, mode, normal, supply, fb_oe, en, wb_oe, share, fb, wb},
			{5'h0, 1'b0, r[11:10], r[11], &r[11:10], r[8],
			r[7] & r[11], r[5] | (|sel), r[4], 2'h0}, "pins");
		check({on_ma, off_ma}, r[4] ? {8'h32, 8'h0f} : {8'h55, 8'h32}, "thresholds");
		check({14'h0, strobe | sel}, 16'h0003, "continuous sampling");
	endtask
	task automatic sys_reset();
		@(negedge core_clk_in) system_reset_in = 1'b1;
		@(negedge core_clk_in) system_reset_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard, well past the expected run length
	initial
	begin
		#400000;
		failures++;
		stop_test();
	end
	initial
	begin
		void'($urandom(20788));
		repeat (12) @(posedge core_clk_in);
		@(negedge core_clk_in) reset_in = 1'b0;
		r = 16'h2200;
		rd_check();
		// random legal writes, mixed with sample selects
		repeat (20)
		begin
			w = 16'($urandom);
			sel = 2'($urandom);
			w[15:12] = 4'h2;
			host.frame(w, 16, rx);
			r = exp_word(w);
			rd_check();
		end
		// locked, foreign address, short and long frames are all dropped
		for (int k = 0; k < 4; k++)
		begin
			w = 16'($urandom);
			w[15:12] = (k == 0) ? 4'h3 : ((k == 1) ? 4'h4 : 4'h2);
			host.frame(w, (k == 2) ? 15 : ((k == 3) ? 17 : 16), rx);
			rd_check();
		end
		sel = 2'h0;
		host.frame(16'h2200, 16, rx);
		sys_reset();
		r = 16'h2300;
		rd_check();
		host.frame(16'h2000, 16, rx);
		sys_reset();
		r = 16'h2200;
		rd_check();
		// sampled input pulses twice per two periods; period 16 or 64 ms
		for (int k = 0; k < 2; k++)
		begin
			host.frame(k ? 16'h2020 : 16'h2000, 16, rx);
			sel = 2'h3;
			cnt = 16'h0000;
			// both inputs sampled: two pulses each over two periods
			repeat (k ? 1280 : 320) @(negedge core_clk_in) cnt = cnt + {15'h0, strobe[0]} + {15'h0, strobe[1]};
			check(cnt, 16'h0004, "sample period");
		end
		stop_test();
	end
endmodule
